// *** verilog/program_memory_table_access.sv ***
// Table read and table write unit with an AHB-Lite register port.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Latched table read returns selected latch byte to the destination.
// - Then it loads the pointed 16-bit program word into the latch.
// - Increment operand 1 advances pointer after access; 0 leaves it.
// - Internal table write starts long programming cycle; execution halts meanwhile.
// - Long write ends only on reset or enabled and flagged interrupt.
// - Ending core source flag, highest priority enabled, is cleared automatically.
// - Core source pending at internal write aborts it as no-operation, clears flag.
// - Peripheral interrupt ending long write keeps its flag set.
// - On termination vector if global disable is 0, else resume.
// - Without programming voltage internal write takes two cycles, no change.
// - External table write takes two cycles, data driven in second.
// - External write completes despite interrupts; core flag cleared or peripheral acknowledged.
// - External mode keeps separate read and write latches.
// - First table read returns old latch contents, later reads fetched words.
// - Table write places byte into selected latch half, then writes word.
// - Two byte registers form the 16-bit program word pointer; here one 16-bit register at PTR_OFS holds it.
// - Table accesses reach external memory only in external program modes.
module program_memory_table_access (
   input  wire logic                           hclk,            // Core instruction clock.
   input  wire logic                           hresetn,         // Asynchronous reset, active low.
   input  wire logic                           hsel,            // AHB-Lite slave select.
   input  wire logic [31:0]                    haddr,           // AHB-Lite address.
   input  wire logic [1:0]                     htrans,          // AHB-Lite transfer type.
   input  wire logic                           hwrite,          // AHB-Lite write flag.
   input  wire logic [31:0]                    hwdata,          // AHB-Lite write data.
   input  wire logic                           hready,          // AHB-Lite bus ready.
   output logic      [31:0]                    hrdata,          // AHB-Lite read data.
   output logic                                hreadyout,       // AHB-Lite slave ready.
   output logic                                hresp,           // AHB-Lite response, always OKAY.
   input  wire logic [tbl_pkg::CORE_SRCS-1:0] core_irq_en,     // Core source enables.
   input  wire logic [tbl_pkg::CORE_SRCS-1:0] core_irq_flag,   // Core source flags.
   input  wire logic                           periph_irq_pend, // Peripheral enable and flag both set.
   input  wire logic                           global_irq_disable, // Vectoring disable.
   input  wire logic                           prog_voltage_pin,   // Programming voltage present.
   input  wire logic [15:0]                    mem_rdata,       // Program word, valid while rd is high.
   output tbl_pkg::mem_req_s                   mem_req,         // Program memory request.
   output tbl_pkg::irq_act_s                   irq_act,         // Flag clears, acknowledge, vector.
   output logic                                cpu_halt         // Execution halted by a long write.
);
   import tbl_pkg::*;

   typedef struct packed {
      st_e         st;
      logic        hreadyout;
      logic        hresp;
      logic [31:0] hrdata;
      logic        ap_wr;
      logic [7:0]  ap_addr;
      logic        ext_mode;
      logic [15:0] ptr;
      logic [15:0] rd_lat;
      logic [15:0] wr_lat;
      logic        inc;
      logic [7:0]  result;
      logic        aborted;
      logic        halt;
      logic        vpp_meta;
      logic        vpp;
      mem_req_s    mem;
      irq_act_s    irq;
   } state_s;

   state_s                 q;
   state_s                 d;
   logic [CORE_SRCS-1:0]   core_pend;
   logic                   term;
   logic                   cmd_go;
   op_e                    cmd_op;
   logic                   cmd_hi;
   logic [7:0]             cmd_byte;
   logic [7:0]             rd_byte;
   logic [15:0]            wr_new;
   logic [31:0]            rd_mux;

   // Isolates the highest priority (lowest index) pending source.
   function automatic logic [CORE_SRCS-1:0] prio(input logic [CORE_SRCS-1:0] p);
      prio = p & (~p + {{(CORE_SRCS-1){1'b0}}, 1'b1});
   endfunction

   assign core_pend = core_irq_en & core_irq_flag;
   assign term      = (|core_pend) | periph_irq_pend;
   assign cmd_go    = q.ap_wr && (q.ap_addr == CMD_OFS) && (q.st == ST_IDLE);
   assign cmd_op    = op_e'(hwdata[CMD_OP_LSB +: 2]);
   assign cmd_hi    = hwdata[CMD_HI_BIT];
   assign cmd_byte  = hwdata[CMD_DATA_LSB +: 8];
   assign rd_byte   = cmd_hi ? q.rd_lat[15:8] : q.rd_lat[7:0];
   assign wr_new    = cmd_hi ? {cmd_byte, q.wr_lat[7:0]} : {q.wr_lat[15:8], cmd_byte};

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (haddr[ADDR_W-1:0])
         CTRL_OFS: rd_mux[CTRL_EXT_BIT] = q.ext_mode;
         PTR_OFS: rd_mux[15:0] = q.ptr;
         STAT_OFS: begin
            rd_mux[STAT_BUSY_BIT]        = (q.st != ST_IDLE);
            rd_mux[STAT_HALT_BIT]        = q.halt;
            rd_mux[STAT_ABORT_BIT]       = q.aborted;
            rd_mux[STAT_EXT_BIT]         = q.ext_mode;
            rd_mux[STAT_RESULT_LSB +: 8] = q.result;
         end
         LATCH_OFS: rd_mux = {q.wr_lat, q.rd_lat};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      d                  = q;
      d.hreadyout        = 1'b1;
      d.hresp            = 1'b0;
      d.mem.rd           = 1'b0;
      d.mem.ext_we       = 1'b0;
      d.irq              = '0;
      // The first stage feeds only the second.
      d.vpp_meta         = prog_voltage_pin;
      d.vpp              = q.vpp_meta;
      if (hready) begin
         d.ap_wr   = hsel && htrans[1] && hwrite;
         d.ap_addr = haddr[ADDR_W-1:0];
         d.hrdata  = (hsel && htrans[1] && !hwrite) ? rd_mux : 32'h0000_0000;
      end
      // Pointer and mode writes are ignored while an access runs, so a pointer never moves mid-access.
      if (q.ap_wr && q.st == ST_IDLE) begin
         case (q.ap_addr)
            CTRL_OFS: d.ext_mode = hwdata[CTRL_EXT_BIT];
            PTR_OFS: d.ptr = hwdata[15:0];
            default: d.ptr = q.ptr;
         endcase
      end
      case (q.st)
         ST_IDLE: begin
            if (cmd_go) begin
               d.inc     = hwdata[CMD_INC_BIT];
               d.aborted = 1'b0;
               d.mem.addr = q.ptr;
               d.mem.ext  = q.ext_mode;
               case (cmd_op)
                  OP_LATCH_RD: d.result = rd_byte;
                  OP_LATCH_WR: begin
                     d.wr_lat = wr_new;
                     if (!q.ext_mode) begin
                        d.rd_lat = wr_new;
                     end
                  end
                  OP_TABLE_RD: begin
                     d.result = rd_byte;
                     d.mem.rd = 1'b1;
                     d.st     = ST_RD2;
                  end
                  OP_TABLE_WR: begin
                     d.wr_lat    = wr_new;
                     d.mem.wdata = wr_new;
                     if (!q.ext_mode) begin
                        d.rd_lat = wr_new;
                     end
                     if (q.ext_mode) begin
                        d.mem.ext_we = 1'b1;
                        d.st         = ST_WR2;
                     end else if (|core_pend) begin
                        d.aborted      = 1'b1;
                        d.irq.core_clr = prio(core_pend);
                     end else if (!q.vpp) begin
                        d.st = ST_WR2;
                     end else begin
                        d.mem.prog = 1'b1;
                        d.halt     = 1'b1;
                        d.st       = ST_LONG;
                     end
                  end
                  default: d.result = q.result;
               endcase
            end
         end
         ST_RD2: begin
            d.rd_lat = mem_rdata;
            if (!q.mem.ext) begin
               d.wr_lat = mem_rdata;
            end
            if (q.inc) begin
               d.ptr = q.ptr + 16'h0001;
            end
            d.st = ST_IDLE;
         end
         ST_WR2: begin
            if (q.mem.ext) begin
               if (|core_pend) begin
                  d.irq.core_clr = prio(core_pend);
               end else begin
                  d.irq.periph_ack = periph_irq_pend;
               end
            end
            if (q.inc) begin
               d.ptr = q.ptr + 16'h0001;
            end
            d.st = ST_IDLE;
         end
         ST_LONG: begin
            // only enabled flagged source ends it
            if (term) begin
               d.mem.prog = 1'b0;
               d.halt     = 1'b0;
               d.irq.core_clr = prio(core_pend);
               d.irq.vector_req = !global_irq_disable;
               if (q.inc) begin
                  d.ptr = q.ptr + 16'h0001;
               end
               d.st = ST_IDLE;
            end
         end
         default: d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q           <= '0;
         q.st        <= ST_IDLE;
         q.hreadyout <= 1'b1;
         q.ext_mode  <= EXT_RST;
         q.ptr       <= PTR_RST;
         q.rd_lat    <= LATCH_RST;
         q.wr_lat    <= LATCH_RST;
      end else begin
         q <= d;
      end
   end

   assign hrdata    = q.hrdata;
   assign hreadyout = q.hreadyout;
   assign hresp     = q.hresp;
   assign mem_req   = q.mem;
   assign irq_act   = q.irq;
   assign cpu_halt  = q.halt;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   rd_result_a: assert property (cmd_go && cmd_op == OP_TABLE_RD |=> q.result == $past(rd_byte))
      else $error("Table read returned the wrong latch byte.");
   rd_load_a: assert property (q.st == ST_RD2 |=> q.rd_lat == $past(mem_rdata) && q.st == ST_IDLE)
      else $error("Table read did not load the program word.");
   ptr_step_a: assert property (q.st == ST_RD2 |=> q.ptr == $past(q.ptr) + {15'h0000, $past(q.inc)})
      else $error("Pointer did not follow the increment operand.");
   long_halt_a: assert property (q.st == ST_LONG |-> cpu_halt && mem_req.prog)
      else $error("Long write without halt or programming.");
   long_hold_a: assert property (q.st == ST_LONG && !term |=> q.st == ST_LONG && cpu_halt)
      else $error("Long write ended without an enabled source.");
   core_clear_a: assert property (q.st == ST_LONG && term |=> irq_act.core_clr == prio($past(core_pend)) && !cpu_halt)
      else $error("Wrong core flag cleared at long write end.");
   abort_nop_a: assert property (cmd_go && cmd_op == OP_TABLE_WR && !q.ext_mode && (|core_pend)
                                 |=> q.st == ST_IDLE && q.aborted && !mem_req.prog)
      else $error("Pending core source did not abort the write.");
   vector_sel_a: assert property (q.st == ST_LONG && term |=> irq_act.vector_req == !$past(global_irq_disable))
      else $error("Vectoring does not follow the global disable.");
   no_vpp_a: assert property (cmd_go && cmd_op == OP_TABLE_WR && !q.ext_mode && !(|core_pend) && !q.vpp
                              |=> q.st == ST_WR2 && !mem_req.prog ##1 q.st == ST_IDLE)
      else $error("Write without programming voltage is not two cycles.");
   ext_write_a: assert property (cmd_go && cmd_op == OP_TABLE_WR && q.ext_mode
                                 |=> mem_req.ext_we && mem_req.wdata == $past(wr_new) ##1 !mem_req.ext_we)
      else $error("External write strobe is not one cycle in the second cycle.");
   periph_keep_a: assert property (q.st == ST_LONG && term && !(|core_pend)
                                   |=> !(|irq_act.core_clr) && !irq_act.periph_ack)
      else $error("Peripheral end of a long write touched a flag.");
   ext_clear_a: assert property (q.st == ST_WR2 && q.mem.ext |=> irq_act.core_clr == prio($past(core_pend)))
      else $error("External write end cleared the wrong core flag.");
   ext_ack_a: assert property (q.st == ST_WR2 && q.mem.ext && !(|core_pend)
                               |=> irq_act.periph_ack == $past(periph_irq_pend))
      else $error("External write end did not acknowledge the peripheral.");
   split_latch_a: assert property (q.st == ST_RD2 && q.mem.ext |=> q.wr_lat == $past(q.wr_lat))
      else $error("External table read changed the write latch.");
   latch_half_a: assert property (cmd_go && cmd_op == OP_TABLE_WR |=> q.wr_lat == $past(wr_new))
      else $error("Table write did not place the byte into the latch.");
   latch_only_a: assert property (cmd_go && (cmd_op == OP_LATCH_RD || cmd_op == OP_LATCH_WR)
                                  |=> !mem_req.rd && !mem_req.ext_we && q.ptr == $past(q.ptr))
      else $error("Latch-only access touched memory or the pointer.");
   ext_route_a: assert property ((mem_req.rd || mem_req.ext_we) |-> mem_req.ext == q.ext_mode)
      else $error("Program memory access took the wrong route.");
endmodule

`default_nettype wire

// *** verilog/tbl_pkg.sv ***
// Package for the program memory table access unit: register map, fields, states and carriers.
package tbl_pkg;
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  CTRL_OFS        = 8'h00;
   localparam logic [7:0]  PTR_OFS         = 8'h04;
   localparam logic [7:0]  CMD_OFS         = 8'h08;
   localparam logic [7:0]  STAT_OFS        = 8'h0C;
   localparam logic [7:0]  LATCH_OFS       = 8'h10;
   localparam int          CTRL_EXT_BIT    = 0;
   localparam int          CMD_OP_LSB      = 0;
   localparam int          CMD_HI_BIT      = 2;
   localparam int          CMD_INC_BIT     = 3;
   localparam int          CMD_DATA_LSB    = 8;
   localparam int          STAT_BUSY_BIT   = 0;
   localparam int          STAT_HALT_BIT   = 1;
   localparam int          STAT_ABORT_BIT  = 2;
   localparam int          STAT_EXT_BIT    = 3;
   localparam int          STAT_RESULT_LSB = 8;
   localparam int          LATCH_WR_LSB    = 16;
   localparam logic [15:0] PTR_RST         = 16'h0000;
   localparam logic [15:0] LATCH_RST       = 16'h0000;
   localparam logic        EXT_RST         = 1'b0;
   localparam int          CORE_SRCS       = 3;

   typedef enum logic [1:0] {
      OP_LATCH_RD = 2'h0,
      OP_LATCH_WR = 2'h1,
      OP_TABLE_RD = 2'h2,
      OP_TABLE_WR = 2'h3
   } op_e;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RD2  = 4'h2,
      ST_WR2  = 4'h4,
      ST_LONG = 4'h8
   } st_e;

   // Program memory request; ext selects the external system bus.
   typedef struct packed {
      logic        rd;
      logic        ext_we;
      logic        prog;
      logic        ext;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_req_s;

   // Answers to the interrupt controller; bit 0 of core_clr is the external pin source.
   typedef struct packed {
      logic [CORE_SRCS-1:0] core_clr;
      logic                 periph_ack;
      logic                 vector_req;
   } irq_act_s;
endpackage

// *** testbench/prog_mem_model.sv ***
// Program memory model that answers table reads and stores external table writes.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
   input  wire logic              hclk,      // Core clock.
   input  wire tbl_pkg::mem_req_s mem_req,   // Request from the unit.
   output logic       [15:0]      mem_rdata  // Program word.
);
   import tbl_pkg::*;
   logic [15:0] mem [16];
   logic [15:0] last_q;
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'hA000 + 16'(i);
      end
      last_q = 16'h0000;
   end
   // word fetch
   // Outside a read the bus shows the inverse of the last word, so stale data never passes for a fetch.
   assign mem_rdata = mem_req.rd ? mem[mem_req.addr[3:0]] : ~last_q;
   always @(posedge hclk) begin
      if (mem_req.rd) begin
         last_q <= mem[mem_req.addr[3:0]];
      end
      if (mem_req.ext_we && mem_req.ext) begin
         mem[mem_req.addr[3:0]] <= mem_req.wdata;
      end
   end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the table access unit, driven over its register port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tbl_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   wire logic   hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [2:0]  core_irq_en = 3'h0;
   logic [2:0]  core_irq_flag = 3'h0;
   logic        periph_irq_pend = 1'b0;
   logic        global_irq_disable = 1'b0;
   logic        prog_voltage_pin = 1'b0;
   logic [15:0] mem_rdata;
   mem_req_s    mem_req;
   irq_act_s    irq_act;
   logic        cpu_halt;
   int          failures = 0;
   int          checked = 0;
   assign hready = hreadyout;
   always #2.5 hclk = ~hclk;
   program_memory_table_access i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .core_irq_en(core_irq_en), .core_irq_flag(core_irq_flag),
      .periph_irq_pend(periph_irq_pend), .global_irq_disable(global_irq_disable),
      .prog_voltage_pin(prog_voltage_pin), .mem_rdata(mem_rdata), .mem_req(mem_req), .irq_act(irq_act),
      .cpu_halt(cpu_halt));
   prog_mem_model i_mem (.hclk(hclk), .mem_req(mem_req), .mem_rdata(mem_rdata));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask
   // One single transfer; the master waits for hready in both phases.
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(a, 1'b1, d, r);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
      logic [31:0] r;
      ahb(a, 1'b0, 32'h0, r);
      chk(n, e & m, r & m);
   endtask
   // Waits for the edge after an interrupt input changes, then lets that edge's updates land.
   task automatic edge_settle();
      @(posedge hclk);
      #1;
   endtask
   task automatic test_done();
      $display("TB: checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #20000;
      failures++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(PTR_OFS, 32'hFFFF, 32'h0, "ptr reset");
      rchk(LATCH_OFS, 32'hFFFFFFFF, 32'h0, "latch reset");
      rchk(CMD_OFS, 32'hFFFFFFFF, 32'h0, "cmd reads zero");
      rchk(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped");
      $display("TB: reset test done");
      wr(PTR_OFS, 32'h5);
      wr(CMD_OFS, 32'h0000000E);
      #1 chk("fetch rd", 32'h1, {31'h0, mem_req.rd});
      chk("fetch addr", 32'h5, {16'h0, mem_req.addr});
      rchk(STAT_OFS, 32'hFF00, 32'h0, "first read old");
      rchk(LATCH_OFS, 32'hFFFFFFFF, 32'hA005A005, "latch fetched");
      rchk(PTR_OFS, 32'hFFFF, 32'h6, "ptr inc");
      wr(CMD_OFS, 32'h00000002);
      rchk(STAT_OFS, 32'hFF00, 32'h0500, "low byte");
      rchk(PTR_OFS, 32'hFFFF, 32'h6, "ptr held");
      $display("TB: table read test done");
      wr(CMD_OFS, 32'h0000A505);
      #1 chk("no fetch", 32'h0, {31'h0, mem_req.rd});
      rchk(LATCH_OFS, 32'hFFFFFFFF, 32'hA506A506, "latch byte write");
      wr(CMD_OFS, 32'h00000004);
      rchk(STAT_OFS, 32'hFF00, 32'hA500, "latch byte read");
      wr(CMD_OFS, 32'h0000110B);
      #1 chk("no halt", 32'h0, {31'h0, cpu_halt | mem_req.prog});
      rchk(PTR_OFS, 32'hFFFF, 32'h7, "short write ptr");
      rchk(LATCH_OFS, 32'hFFFFFFFF, 32'hA511A511, "latch low half");
      $display("TB: latch and short write test done");
      prog_voltage_pin <= 1'b1;
      core_irq_en <= 3'b101;
      core_irq_flag <= 3'b101;
      repeat (3) @(posedge hclk);
      wr(CMD_OFS, 32'h0000000B);
      #1 chk("abort clear", 32'h1, {29'h0, irq_act.core_clr});
      chk("abort no halt", 32'h0, {31'h0, cpu_halt});
      rchk(STAT_OFS, 32'h4, 32'h4, "abort flag");
      rchk(PTR_OFS, 32'hFFFF, 32'h7, "abort ptr");
      core_irq_en <= 3'b010;
      core_irq_flag <= 3'b000;
      wr(CMD_OFS, 32'h00007707);
      #1 chk("long halt", 32'h1, {31'h0, cpu_halt & mem_req.prog});
      repeat (6) @(posedge hclk);
      core_irq_flag <= 3'b010;
      #1 chk("halt holds", 32'h1, {31'h0, cpu_halt});
      edge_settle();
      chk("long end", 32'h0, {31'h0, cpu_halt});
      chk("core clear", 32'h2, {29'h0, irq_act.core_clr});
      chk("vector", 32'h1, {31'h0, irq_act.vector_req});
      @(posedge hclk);
      core_irq_flag <= 3'b000;
      rchk(PTR_OFS, 32'hFFFF, 32'h7, "long ptr held");
      global_irq_disable <= 1'b1;
      wr(CMD_OFS, 32'h0000000B);
      repeat (2) @(posedge hclk);
      periph_irq_pend <= 1'b1;
      edge_settle();
      chk("periph end", 32'h0, {31'h0, cpu_halt});
      chk("periph flag kept", 32'h0, {28'h0, irq_act.core_clr, irq_act.periph_ack});
      chk("no vector", 32'h0, {31'h0, irq_act.vector_req});
      @(posedge hclk);
      periph_irq_pend <= 1'b0;
      rchk(PTR_OFS, 32'hFFFF, 32'h8, "long ptr inc");
      $display("TB: long write test done");
      wr(CTRL_OFS, 32'h1);
      wr(PTR_OFS, 32'h3);
      wr(CMD_OFS, 32'h00003C05);
      core_irq_flag <= 3'b010;
      wr(CMD_OFS, 32'h00005A0B);
      #1 chk("ext we", 32'h3, {30'h0, mem_req.ext_we, mem_req.ext});
      chk("ext word", 32'h00033C5A, {mem_req.addr, mem_req.wdata});
      chk("ext no halt", 32'h0, {31'h0, cpu_halt});
      edge_settle();
      chk("ext clear", 32'h2, {29'h0, irq_act.core_clr});
      @(posedge hclk);
      core_irq_flag <= 3'b000;
      rchk(STAT_OFS, 32'h8, 32'h8, "ext status");
      wr(CMD_OFS, 32'h00000002);
      #1 chk("ext fetch", 32'h1, {31'h0, mem_req.ext});
      rchk(LATCH_OFS, 32'hFFFFFFFF, 32'h3C5AA004, "split latches");
      wr(PTR_OFS, 32'h3);
      wr(CMD_OFS, 32'h00000002);
      rchk(LATCH_OFS, 32'hFFFF, 32'h3C5A, "ext stored");
      periph_irq_pend <= 1'b1;
      wr(CMD_OFS, 32'h0000660B);
      edge_settle();
      chk("ext periph ack", 32'h1, {31'h0, irq_act.periph_ack});
      @(posedge hclk);
      periph_irq_pend <= 1'b0;
      $display("TB: external test done");
      test_done();
   end
endmodule
`default_nettype wire
